// [logic/chan_cfg_regs.sv]
// Register access over Avalon-MM was chosen for this implementation.
`timescale 1ns/1ps
module chan_cfg_regs (
    // clock and reset
    input wire logic sys_clk,
    input wire logic arst_n,
    // avalon-mm slave
    input wire logic [9:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    output logic [1:0] avs_response,
    // settings to the signal path
    output chan_cfg_pkg::chan_settings_t ch1_settings_r,
    output chan_cfg_pkg::chan_settings_t ch2_settings_r,
    output logic [7:0] ch2_gain_field_r,
    output logic global_agc_mode_r
);
    logic [7:0] index;
    logic wr_ok;
    logic done_r;
    logic [7:0] vol_r;
    logic [7:0] trim_r;
    logic [7:0] phase_r;
    logic [7:0] input_r;
    logic [7:0] chgain_r;
    logic [7:0] glob_r;
    logic [7:0] rd_nxt;
    logic err_nxt;
    logic muted;
    logic [9:0] halfdb;
    logic [4:0] tenth;
    logic [1:0] src_bits;
    logic [1:0] imp_bits;
    logic [7:0] wdata;

    assign index = avs_address[9:2];
    assign wdata = avs_writedata[7:0];
    // write lands only on the accepting edge, low lane enabled
    assign wr_ok = avs_write && !done_r && avs_byteenable[0];
    assign src_bits = wdata[chan_cfg_pkg::bit_src_hi:chan_cfg_pkg::bit_src_lo];
    assign imp_bits = wdata[chan_cfg_pkg::bit_imp_hi:chan_cfg_pkg::bit_imp_lo];

    field_reg #(.rst_val(chan_cfg_pkg::rst_volume), .wmask(8'hff)) u_vol ( // [R3]
        .sys_clk(sys_clk), .arst_n(arst_n),
        .wr_en(wr_ok && index == chan_cfg_pkg::idx_volume),
        .wr_data(wdata), .value_r(vol_r)
    );
    field_reg #(.rst_val(chan_cfg_pkg::rst_gain_trim),
        .wmask(chan_cfg_pkg::mask_gain_trim)) u_trim ( // [R5]
        .sys_clk(sys_clk), .arst_n(arst_n),
        .wr_en(wr_ok && index == chan_cfg_pkg::idx_gain_trim),
        .wr_data(wdata), .value_r(trim_r)
    );
    field_reg #(.rst_val(chan_cfg_pkg::rst_phase), .wmask(8'hff)) u_phase ( // [R7]
        .sys_clk(sys_clk), .arst_n(arst_n),
        .wr_en(wr_ok && index == chan_cfg_pkg::idx_phase_trim),
        .wr_data(wdata), .value_r(phase_r)
    );
    // reserved source and impedance codes are refused, register kept
    field_reg #(.rst_val(chan_cfg_pkg::rst_input), .wmask(chan_cfg_pkg::mask_input)) u_in (
        .sys_clk(sys_clk), .arst_n(arst_n),
        .wr_en(wr_ok && index == chan_cfg_pkg::idx_input_setup
            && src_bits != chan_cfg_pkg::code_reserved
            && imp_bits != chan_cfg_pkg::code_reserved), // [R15]
        .wr_data(wdata), .value_r(input_r)
    );
    field_reg #(.rst_val(chan_cfg_pkg::rst_ch_gain),
        .wmask(chan_cfg_pkg::mask_ch_gain)) u_chg (
        .sys_clk(sys_clk), .arst_n(arst_n),
        .wr_en(wr_ok && index == chan_cfg_pkg::idx_channel_gain),
        .wr_data(wdata), .value_r(chgain_r)
    );
    field_reg #(.rst_val(chan_cfg_pkg::rst_global), .wmask(chan_cfg_pkg::mask_global)) u_glb (
        .sys_clk(sys_clk), .arst_n(arst_n),
        .wr_en(wr_ok && index == chan_cfg_pkg::idx_global_agc),
        .wr_data(wdata), .value_r(glob_r)
    );

    volume_map u_map (
        .volume_code(vol_r),
        .trim_code(trim_r[7:4]),
        .muted(muted),
        .halfdb_rel_unity(halfdb),
        .trim_tenth_db(tenth)
    );

    // read mux; reserved bits are already zero in storage
    always_comb begin
        rd_nxt = 8'h00;
        err_nxt = 1'b0;
        unique case (index)
            chan_cfg_pkg::idx_volume: rd_nxt = vol_r;
            chan_cfg_pkg::idx_gain_trim: rd_nxt = trim_r;
            chan_cfg_pkg::idx_phase_trim: rd_nxt = phase_r;
            chan_cfg_pkg::idx_input_setup: rd_nxt = input_r;
            chan_cfg_pkg::idx_channel_gain: rd_nxt = chgain_r;
            chan_cfg_pkg::idx_global_agc: rd_nxt = glob_r;
            default: err_nxt = 1'b1;
        endcase
    end

    // one wait cycle per access, then a one-cycle answer
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            done_r <= 1'b0;
        end else begin
            done_r <= (avs_read || avs_write) && !done_r;
        end
    end

    // waitrequest idles high and drops only for the answer cycle
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            avs_waitrequest <= 1'b1;
        end else begin
            avs_waitrequest <= !((avs_read || avs_write) && !done_r);
        end
    end

    // read data and response captured for the answer cycle
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            avs_readdata <= chan_cfg_pkg::unmapped_read;
            avs_response <= 2'h0;
        end else if ((avs_read || avs_write) && !done_r) begin
            avs_readdata <= {24'h000000, rd_nxt};
            avs_response <= err_nxt ? 2'h3 : 2'h0; // decodeerror when unmapped
        end
    end

    // channel 1 decoded settings
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            ch1_settings_r <= '0;
        end else begin
            ch1_settings_r.muted <= muted; // [R1]
            ch1_settings_r.volume_code <= vol_r;
            ch1_settings_r.volume_halfdb_unity <= halfdb; // [R2]
            ch1_settings_r.trim_code <= trim_r[7:4];
            ch1_settings_r.trim_tenth_db <= tenth; // [R4]
            ch1_settings_r.phase_delay <= phase_r; // [R6]
            ch1_settings_r.line_input <= 1'b0;
            ch1_settings_r.source <= chan_cfg_pkg::src_analog_diff;
            ch1_settings_r.dc_coupled <= 1'b0;
            ch1_settings_r.impedance <= chan_cfg_pkg::imp_2k5;
            ch1_settings_r.agc_on <= 1'b0;
        end
    end

    // channel 2 input setup; coupling masked off for the digital mic
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            ch2_settings_r <= '0;
        end else begin
            ch2_settings_r.muted <= 1'b0;
            ch2_settings_r.volume_code <= chan_cfg_pkg::rst_volume;
            ch2_settings_r.volume_halfdb_unity <= 10'h000;
            ch2_settings_r.trim_code <= chan_cfg_pkg::trim_unity;
            ch2_settings_r.trim_tenth_db <= 5'h00;
            ch2_settings_r.phase_delay <= chan_cfg_pkg::rst_phase;
            ch2_settings_r.line_input <= input_r[chan_cfg_pkg::bit_kind]; // [R8]
            ch2_settings_r.source <= chan_cfg_pkg::source_t'(
                input_r[chan_cfg_pkg::bit_src_hi:chan_cfg_pkg::bit_src_lo]); // [R9]
            ch2_settings_r.dc_coupled <= input_r[chan_cfg_pkg::bit_coupling]
                && input_r[chan_cfg_pkg::bit_src_hi:chan_cfg_pkg::bit_src_lo]
                != chan_cfg_pkg::src_digital_mic; // [R12]
            ch2_settings_r.impedance <= chan_cfg_pkg::impedance_t'(
                input_r[chan_cfg_pkg::bit_imp_hi:chan_cfg_pkg::bit_imp_lo]); // [R13]
            ch2_settings_r.agc_on <= input_r[chan_cfg_pkg::bit_agc]; // [R14]
        end
    end

    // raw gain field and global agc mode bit for the path
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            ch2_gain_field_r <= chan_cfg_pkg::rst_ch_gain;
            global_agc_mode_r <= 1'b0;
        end else begin
            ch2_gain_field_r <= chgain_r;
            global_agc_mode_r <= glob_r[chan_cfg_pkg::bit_global_agc]; // [R14]
        end
    end
endmodule

// [logic/chan_cfg_pkg.sv]
// Behaviour
// [R1] volume code zero mutes channel output
// [R2] codes 1-255 half-dB steps, 201 unity
// [R3] volume resets to c9, unity gain
// [R4] gain trim 0.1 dB steps, 8 is 0 dB
// [R5] trim resets to 8, low nibble zero
// [R6] phase code delays by modulator cycles
// [R7] phase delay resets to zero
// [R8] bit 7 selects microphone or line
// [R9] source bits select diff, single, digital mic
// [R10] software frees shared pins for analog
// [R11] software routes shared pins for digital mic
// [R12] bit 4 coupling, ignored for digital mic
// [R13] bits 3-2 select input impedance
// [R14] bit 0 enables auto gain per global
// [R15] reserved bits read zero, ignore writes
package chan_cfg_pkg;
    // register indices; the byte address on the bus is the index times four
    localparam logic [7:0] idx_volume = 8'h3e;
    localparam logic [7:0] idx_gain_trim = 8'h3f;
    localparam logic [7:0] idx_phase_trim = 8'h40;
    localparam logic [7:0] idx_input_setup = 8'h41;
    localparam logic [7:0] idx_channel_gain = 8'h42;
    localparam logic [7:0] idx_global_agc = 8'h6c;
    localparam logic [7:0] rst_volume = 8'hc9;
    localparam logic [7:0] rst_gain_trim = 8'h80;
    localparam logic [7:0] rst_phase = 8'h00;
    localparam logic [7:0] rst_input = 8'h00;
    localparam logic [7:0] rst_ch_gain = 8'h00;
    localparam logic [7:0] rst_global = 8'h00;
    localparam logic [7:0] mask_gain_trim = 8'hf0;
    localparam logic [7:0] mask_input = 8'hfd;
    localparam logic [7:0] mask_ch_gain = 8'hfc;
    localparam logic [7:0] mask_global = 8'h08;
    localparam logic [7:0] vol_mute = 8'h00;
    localparam logic [7:0] vol_unity = 8'hc9;
    localparam logic [3:0] trim_unity = 4'h8;
    localparam logic [1:0] code_reserved = 2'h3;
    localparam int bit_kind = 7;
    localparam int bit_src_hi = 6;
    localparam int bit_src_lo = 5;
    localparam int bit_coupling = 4;
    localparam int bit_imp_hi = 3;
    localparam int bit_imp_lo = 2;
    localparam int bit_agc = 0;
    localparam int bit_global_agc = 3;
    localparam logic [31:0] unmapped_read = 32'h0000_0000;

    typedef enum logic [1:0] {
        src_analog_diff,
        src_analog_single,
        src_digital_mic,
        src_reserved
    } source_t;

    typedef enum logic [1:0] {
        imp_2k5,
        imp_10k,
        imp_20k,
        imp_reserved
    } impedance_t;

    // decoded settings handed to the signal path
    typedef struct packed {
        logic muted;
        logic [7:0] volume_code;
        logic [9:0] volume_halfdb_unity;
        logic [3:0] trim_code;
        logic [4:0] trim_tenth_db;
        logic [7:0] phase_delay;
        logic line_input;
        source_t source;
        logic dc_coupled;
        impedance_t impedance;
        logic agc_on;
    } chan_settings_t;
endpackage

// [logic/field_reg.sv]
`timescale 1ns/1ps
module field_reg #(
    parameter logic [7:0] rst_val = 8'h00,
    parameter logic [7:0] wmask = 8'hff
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic arst_n,
    // write port
    input wire logic wr_en,
    input wire logic [7:0] wr_data,
    // stored value, unwritable bits held at zero
    output logic [7:0] value_r
);
    // masked bits never load, so reserved bits stay zero
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            value_r <= rst_val;
        end else if (wr_en) begin
            value_r <= wr_data & wmask; // [R15]
        end
    end
endmodule

// [logic/volume_map.sv]
`timescale 1ns/1ps
module volume_map (
    // raw fields
    input wire logic [7:0] volume_code,
    input wire logic [3:0] trim_code,
    // decoded
    output logic muted,
    output logic [9:0] halfdb_rel_unity,
    output logic [4:0] trim_tenth_db
);
    // linear maps; signed results in two's complement
    always_comb begin
        muted = (volume_code == chan_cfg_pkg::vol_mute); // [R1]
        halfdb_rel_unity = 10'({2'b00, volume_code} - {2'b00, chan_cfg_pkg::vol_unity}); // [R2]
        trim_tenth_db = 5'({1'b0, trim_code} - {1'b0, chan_cfg_pkg::trim_unity}); // [R4]
    end
endmodule

// [verif/chan_cfg_props.sv]
`timescale 1ns/1ps
module chan_cfg_props (
    // clock and reset
    input wire logic sys_clk,
    input wire logic arst_n,
    // register bus
    input wire logic [9:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic [1:0] avs_response,
    // settings
    input wire chan_cfg_pkg::chan_settings_t ch1_settings_r,
    input wire chan_cfg_pkg::chan_settings_t ch2_settings_r,
    input wire logic [7:0] ch2_gain_field_r,
    input wire logic global_agc_mode_r
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!arst_n);
    logic req_q;
    logic live_q;
    wire req = avs_read | avs_write;
    wire [7:0] ix = avs_address[9:2];
    wire mapped = ix inside {8'h3e, 8'h3f, 8'h40, 8'h41, 8'h42, 8'h6c};
    // waitrequest idles high, so low with a held request is the answer
    wire ans = req & req_q & !avs_waitrequest;
    // settings hold all zero in reset, valid one edge after release
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            req_q <= 1'b0;
            live_q <= 1'b0;
        end else begin
            req_q <= req;
            live_q <= 1'b1;
        end
    end
    unmapped_resp_a: assert property (ans && !mapped |-> avs_response == 2'h3)
        else $error("unmapped access not refused");
    mapped_resp_a: assert property (ans && mapped |-> avs_response == 2'h0)
        else $error("mapped access refused");
    read_upper_a: assert property (ans && avs_read |-> avs_readdata[31:8] == 24'h0)
        else $error("upper read bits not zero");
    mute_code_a: assert property (live_q |-> ch1_settings_r.muted ==
        (ch1_settings_r.volume_code == 8'h00)) else $error("mute not tied to code zero");
    vol_step_a: assert property (live_q && !ch1_settings_r.muted |->
        ch1_settings_r.volume_halfdb_unity == {2'h0, ch1_settings_r.volume_code} - 10'd201)
        else $error("volume step wrong");
    trim_step_a: assert property (live_q |->
        ch1_settings_r.trim_tenth_db == {1'h0, ch1_settings_r.trim_code} - 5'd8)
        else $error("trim step wrong");
    dc_ignored_a: assert property (ch2_settings_r.source == chan_cfg_pkg::src_digital_mic
        |-> !ch2_settings_r.dc_coupled) else $error("coupling active for digital mic");
    no_reserved_a: assert property (ch2_settings_r.source != chan_cfg_pkg::src_reserved &&
        ch2_settings_r.impedance != chan_cfg_pkg::imp_reserved) else $error("reserved code");
    vol_write_a: assert property (ans && avs_write && ix == 8'h3e && avs_byteenable[0] |=>
        ch1_settings_r.volume_code == $past(avs_writedata[7:0])) else $error("volume lost");
    phase_write_a: assert property (ans && avs_write && ix == 8'h40 && avs_byteenable[0] |=>
        ch1_settings_r.phase_delay == $past(avs_writedata[7:0])) else $error("phase lost");
    cover property (ans && avs_write);
    cover property (ans && !mapped);
    cover property (ch1_settings_r.muted);
endmodule

bind chan_cfg_regs chan_cfg_props chk (.sys_clk(sys_clk), .arst_n(arst_n),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .avs_response(avs_response), .ch1_settings_r(ch1_settings_r),
    .ch2_settings_r(ch2_settings_r), .ch2_gain_field_r(ch2_gain_field_r),
    .global_agc_mode_r(global_agc_mode_r));

// [verif/test_chan_cfg_regs.sv]
`timescale 1ns/1ps
module test_chan_cfg_regs;
    logic sys_clk = 1'b0;
    logic arst_n = 1'b0;
    logic [9:0] avs_address = 10'h000;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [3:0] avs_byteenable = 4'hf;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic [1:0] avs_response;
    chan_cfg_pkg::chan_settings_t s1;
    chan_cfg_pkg::chan_settings_t s2;
    logic [7:0] ch2_gain_field_r;
    logic global_agc_mode_r;
    int bad_count = 0;
    int n_tests = 0;
    int cycles = 0;
    logic [31:0] rd;
    logic [1:0] rs;
    chan_cfg_regs uut (.sys_clk(sys_clk), .arst_n(arst_n), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .avs_response(avs_response),
        .ch1_settings_r(s1), .ch2_settings_r(s2), .ch2_gain_field_r(ch2_gain_field_r),
        .global_agc_mode_r(global_agc_mode_r));
    initial begin
        forever #50 sys_clk = ~sys_clk;
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            bad_count++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // request held until waitrequest is seen low; one idle edge after release
    task automatic xfer(input logic w, input logic [7:0] ix, input logic [7:0] d, input logic be);
        avs_address <= {ix, 2'h0};
        avs_writedata <= {24'h0, d};
        avs_byteenable <= {3'h0, be};
        avs_read <= !w;
        avs_write <= w;
        do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        rs = avs_response;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge sys_clk);
    endtask
    task automatic rchk(input logic [7:0] ix, input logic [31:0] exp);
        xfer(1'b0, ix, 8'h00, 1'b1);
        chk(rd, exp);
        chk(32'(rs), 32'h0);
    endtask
    // reset values on the bus and in the decoded settings
    task automatic t_reset();
        rchk(8'h3e, 32'hc9);
        rchk(8'h3f, 32'h80);
        rchk(8'h40, 32'h00);
        rchk(8'h41, 32'h00);
        chk(32'(s1.volume_code), 32'hc9);
        chk(32'(s1.muted), 32'h0);
        chk(32'(s1.volume_halfdb_unity), 32'h0);
        chk(32'(s1.trim_code), 32'h8);
        chk(32'(s1.trim_tenth_db), 32'h0);
        chk(32'(s1.phase_delay), 32'h0);
        $display("reset values done");
    endtask
    // reset pulled mid-run: written registers must fall back
    task automatic t_rerun();
        xfer(1'b1, 8'h3e, 8'h10, 1'b1);
        xfer(1'b1, 8'h3f, 8'h30, 1'b1);
        xfer(1'b1, 8'h40, 8'h22, 1'b1);
        arst_n <= 1'b0;
        repeat (5) @(posedge sys_clk);
        arst_n <= 1'b1;
        @(posedge sys_clk);
        t_reset();
        $display("mid-run reset done");
    endtask
    task automatic t_volume();
        logic [7:0] c[4] = '{8'h00, 8'h01, 8'hc9, 8'hff};
        logic [9:0] h[4] = '{10'h000, 10'h338, 10'h000, 10'h036};
        for (int i = 0; i < 4; i++) begin
            xfer(1'b1, 8'h3e, c[i], 1'b1);
            rchk(8'h3e, 32'(c[i]));
            chk(32'(s1.muted), 32'(c[i] == 8'h00));
            if (i > 0) chk(32'(s1.volume_halfdb_unity), 32'(h[i]));
        end
        // byte lane off: write must not land
        xfer(1'b1, 8'h3e, 8'h55, 1'b0);
        rchk(8'h3e, 32'hff);
        $display("volume done");
    endtask
    task automatic t_trim_phase();
        xfer(1'b1, 8'h3f, 8'hff, 1'b1);
        rchk(8'h3f, 32'hf0);
        chk(32'(s1.trim_tenth_db), 32'h07);
        xfer(1'b1, 8'h3f, 8'h0f, 1'b1);
        rchk(8'h3f, 32'h00);
        chk(32'(s1.trim_tenth_db), 32'h18);
        xfer(1'b1, 8'h40, 8'hff, 1'b1);
        rchk(8'h40, 32'hff);
        chk(32'(s1.phase_delay), 32'hff);
        $display("trim and phase done");
    endtask
    task automatic t_input();
        logic [7:0] d;
        for (int s = 0; s < 3; s++) begin
            d = {1'h1, 2'(s), 1'h1, 2'(s), 2'h3};
            // bench plays software that has already freed the shared pins
            // for analog sources, or routed them to the mic for code 2
            xfer(1'b1, 8'h41, d, 1'b1);
            rchk(8'h41, 32'(d & 8'hfd));
            chk(32'(s2.source), 32'(s));
            chk(32'(s2.dc_coupled), 32'(s != 2));
            chk(32'(s2.impedance), 32'(s));
            chk(32'(s2.line_input), 32'h1);
            chk(32'(s2.agc_on), 32'h1);
        end
        // reserved source or impedance codes are dropped whole
        xfer(1'b1, 8'h41, 8'h60, 1'b1);
        rchk(8'h41, 32'hd9);
        xfer(1'b1, 8'h41, 8'h0c, 1'b1);
        rchk(8'h41, 32'hd9);
        xfer(1'b1, 8'h41, 8'h00, 1'b1);
        rchk(8'h41, 32'h00);
        chk(32'(s2.line_input), 32'h0);
        chk(32'(s2.agc_on), 32'h0);
        $display("input setup done");
    endtask
    task automatic t_bus();
        xfer(1'b0, 8'h00, 8'h00, 1'b1);
        chk(rd, 32'h0);
        chk(32'(rs), 32'h3);
        xfer(1'b1, 8'h7f, 8'hff, 1'b1);
        chk(32'(rs), 32'h3);
        xfer(1'b1, 8'h6c, 8'hff, 1'b1);
        rchk(8'h6c, 32'h08);
        chk(32'(global_agc_mode_r), 32'h1);
        xfer(1'b1, 8'h42, 8'hff, 1'b1);
        rchk(8'h42, 32'hfc);
        chk(32'(ch2_gain_field_r), 32'hfc);
        $display("bus refusals done");
    endtask
    // whole run needs well under a thousand cycles
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            bad_count++;
            conclude();
        end
    end
    initial begin
        repeat (5) @(posedge sys_clk);
        arst_n <= 1'b1;
        @(posedge sys_clk);
        t_reset();
        t_volume();
        t_trim_phase();
        t_input();
        t_bus();
        t_rerun();
        conclude();
    end
endmodule
